// [src/carry_rotate_step.sv]
// One bit of rotate through carry, byte or word, left or right.
// Pure combinational; the caller repeats it once per count unit.
`default_nettype none
module carry_rotate_step
   import stack_rot_pkg::*;
(
   // Operand in
   input wire logic [DW-1:0] value,
   input wire logic carry_in,
   input wire logic word,
   input wire logic left,
   // Rotated operand out
   output logic [DW-1:0] next_value,
   output logic next_carry,
   output logic ovf
);
   // Byte form leaves the high byte untouched
   wire logic top_in = word ? value[15] : value[7];
   wire logic [DW-1:0] left_val = word ? {value[14:0], carry_in}
                                       : {value[15:8], value[6:0], carry_in};
   wire logic [DW-1:0] right_val = word ? {carry_in, value[15:1]}
                                        : {value[15:8], carry_in, value[7:1]};
   assign next_value = left ? left_val : right_val;
   assign next_carry = left ? top_in : value[0];
   // Overflow candidate from the rotated result
   wire logic res_top = word ? next_value[15] : next_value[7];
   wire logic res_second = word ? next_value[14] : next_value[6];
   assign ovf = left ? (res_top ^ next_carry) : (res_top ^ res_second);
endmodule : carry_rotate_step
`default_nettype wire

// [src/push_slot_gen.sv]
// Address and data for one push of the push-all sequence.
// The caller supplies the current slot's register and the latched pointer.
`default_nettype none
module push_slot_gen
   import stack_rot_pkg::*;
(
   // Sequence position
   input wire logic [2:0] slot,
   input wire logic [DW-1:0] slot_word,
   input wire logic [DW-1:0] saved_ptr,
   input wire logic [DW-1:0] cur_ptr,
   // Push to issue
   output logic [DW-1:0] push_addr,
   output logic [DW-1:0] push_word,
   output logic last
);
   // Pointer drops first, then the word lands there
   assign push_addr = cur_ptr - STACK_STEP;
   // Pointer slot stores the value seen before the first push
   assign push_word = (slot == PTR_SLOT) ? saved_ptr : slot_word;
   assign last = (slot == LAST_SLOT);
endmodule : push_slot_gen
`default_nettype wire

// [src/stack_push_and_carry_rotate.sv]
// Stack save and rotate-through-carry datapath with its register file.
// Assumes one clock, a stack memory that takes a word write every cycle,
// and a register port master that never issues both strobes at once.
//
// Behaviour
// - Push-all stores accumulator, count, data, base, pointer, base ptr, src, dst.
// - The pointer image pushed is the value held before the first push.
// - Each push-all step drops the pointer by 2, then writes there.
// - Push-flags drops the pointer by 2, then writes the whole flags word.
// - Neither push operation alters any flag.
// - Left rotate: carry takes top bit, operand shifts left, old carry in.
// - Rotate targets register or memory; count is immediate or count low byte.
// - Left rotate by one sets overflow to top bit xor new carry.
// - Right rotate: carry takes bit zero, operand shifts right, carry to top.
// - Right rotate by one sets overflow to top bit xor next bit.
// - Rotates touch only the carry and overflow flags.
//
// The address map and the plain strobed port were decided locally.
`default_nettype none
module stack_push_and_carry_rotate
   import stack_rot_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [AW-1:0] reg_addr,
   input wire logic [DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DW-1:0] reg_rdata,
   // Stack memory write port
   output logic mem_wr,
   output logic [DW-1:0] mem_addr,
   output logic [DW-1:0] mem_wdata,
   // Processor state
   output logic busy,
   output logic [DW-1:0] stack_pointer,
   output logic [DW-1:0] flags
);

   // True when an address falls in the general register page
   function automatic logic gpr_hit(input logic [AW-1:0] a);
      return a[4:3] == GPR_PAGE;
   endfunction : gpr_hit

   state_e state;
   logic [DW-1:0] gpr [0:GPR_NUM-1];
   logic [DW-1:0] dest_opnd;
   logic [DW-1:0] imm_count;
   logic [DW-1:0] cmd;
   logic done;
   logic [2:0] slot;
   logic [DW-1:0] saved_ptr;
   logic [CNT_W-1:0] rot_cnt;
   logic count_one;
   logic [DW-1:0] work;
   logic work_carry;

   // Register port decode; writes are refused while a sequence runs
   wire logic wr_ok = reg_wr && !busy;
   wire logic wr_cmd = wr_ok && (reg_addr == OFS_CMD);
   wire logic wr_flags = wr_ok && (reg_addr == OFS_FLAGS);
   wire logic wr_dest = wr_ok && (reg_addr == OFS_DEST);
   wire logic wr_imm = wr_ok && (reg_addr == OFS_IMM);
   wire logic wr_gpr = wr_ok && gpr_hit(reg_addr);

   // New command fields
   wire op_e new_op = op_e'(reg_wdata[CMD_OP_LSB +: 2]);
   wire logic new_csrc = reg_wdata[CMD_CSRC_BIT];
   wire logic new_mem = reg_wdata[CMD_MEM_BIT];
   wire logic [2:0] new_reg = reg_wdata[CMD_REG_LSB +: 3];
   wire logic go_all = wr_cmd && (new_op == OP_PUSH_ALL);
   wire logic go_flags = wr_cmd && (new_op == OP_PUSH_FLAGS);
   wire logic go_rot = wr_cmd && ((new_op == OP_ROT_LEFT) || (new_op == OP_ROT_RIGHT));

   // Count source and starting operand of a rotate
   wire logic [CNT_W-1:0] start_count = new_csrc ? gpr[CNT_SLOT][CNT_W-1:0]
                                                 : imm_count[CNT_W-1:0];
   wire logic [DW-1:0] start_value = new_mem ? dest_opnd : gpr[new_reg];
   wire logic zero_go = go_rot && (start_count == '0);

   // Fields of the running command
   wire logic cur_word = cmd[CMD_WORD_BIT];
   wire logic cur_left = (op_e'(cmd[CMD_OP_LSB +: 2]) == OP_ROT_LEFT);
   wire logic cur_mem = cmd[CMD_MEM_BIT];
   wire logic [2:0] cur_reg = cmd[CMD_REG_LSB +: 3];

   // One rotate step per cycle
   logic [DW-1:0] step_value;
   logic step_carry;
   logic step_ovf;
   carry_rotate_step u_step (
      .value(work),
      .carry_in(work_carry),
      .word(cur_word),
      .left(cur_left),
      .next_value(step_value),
      .next_carry(step_carry),
      .ovf(step_ovf)
   );

   // One push of the push-all sequence per cycle
   logic [DW-1:0] push_addr;
   logic [DW-1:0] push_word;
   logic push_last;
   push_slot_gen u_push (
      .slot(slot),
      .slot_word(gpr[slot]),
      .saved_ptr(saved_ptr),
      .cur_ptr(gpr[PTR_SLOT]),
      .push_addr(push_addr),
      .push_word(push_word),
      .last(push_last)
   );

   // Sequence events
   wire logic in_push = (state == ST_PUSH);
   wire logic in_rot = (state == ST_ROT);
   wire logic rot_fin = in_rot && (rot_cnt == 8'h01);
   wire logic fin = (in_push && push_last) || rot_fin || go_flags || zero_go;

   // Next state
   state_e next_state;
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (go_all) begin
               next_state = ST_PUSH;
            end else if (go_rot && !zero_go) begin
               next_state = ST_ROT;
            end
         end
         ST_PUSH: begin
            if (push_last) begin
               next_state = ST_IDLE;
            end
         end
         ST_ROT: begin
            if (rot_fin) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // State and busy flag
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         busy <= 1'b0;
      end else begin
         state <= next_state;
         busy <= (next_state != ST_IDLE);
      end
   end

   // General register write source: bus, pointer update or rotate result
   wire logic ptr_dec = in_push || go_flags;
   wire logic rot_wb = rot_fin && !cur_mem;
   wire logic gpr_we = wr_gpr || ptr_dec || rot_wb;
   wire logic [2:0] gpr_widx = ptr_dec ? PTR_SLOT : rot_wb ? cur_reg : reg_addr[2:0];
   wire logic [DW-1:0] gpr_wval = ptr_dec ? (gpr[PTR_SLOT] - STACK_STEP)
                                : rot_wb ? step_value : reg_wdata;

   // General registers; slot 4 is the stack pointer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < GPR_NUM; i++) begin
            gpr[i] <= GPR_RST;
         end
      end else if (gpr_we) begin
         gpr[gpr_widx] <= gpr_wval;
      end
   end
   assign stack_pointer = gpr[PTR_SLOT];

   // Flags: bus write, or carry and overflow at the end of a rotate
   wire logic [DW-1:0] rot_flags = {flags[15:12], count_one ? step_ovf : flags[FLG_OVERFLOW],
                                    flags[10:1], step_carry};
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= FLAGS_RST;
      end else if (wr_flags) begin
         flags <= reg_wdata;
      end else if (rot_fin) begin
         flags <= rot_flags;
      end
   end

   // Command latch, operand registers and done flag
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd <= DATA_RST;
         dest_opnd <= DATA_RST;
         imm_count <= DATA_RST;
         done <= 1'b0;
      end else begin
         if (wr_cmd) cmd <= reg_wdata;
         if (wr_dest) dest_opnd <= reg_wdata;
         else if (rot_fin && cur_mem) dest_opnd <= step_value;
         if (wr_imm) imm_count <= reg_wdata;
         done <= fin ? 1'b1 : (wr_cmd ? 1'b0 : done);
      end
   end

   // Push-all slot counter and latched pointer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         slot <= 3'h0;
         saved_ptr <= DATA_RST;
      end else if (go_all) begin
         slot <= 3'h0;
         saved_ptr <= gpr[PTR_SLOT];
      end else if (in_push) begin
         slot <= slot + 3'h1;
      end
   end

   // Rotate working copy; the loop runs once per count unit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         work <= DATA_RST;
         work_carry <= 1'b0;
         rot_cnt <= '0;
         count_one <= 1'b0;
      end else if (go_rot) begin
         work <= start_value;
         work_carry <= flags[FLG_CARRY];
         rot_cnt <= start_count;
         count_one <= (start_count == 8'h01);
      end else if (in_rot) begin
         work <= step_value;
         work_carry <= step_carry;
         rot_cnt <= rot_cnt - 8'h01;
      end
   end

   // Stack memory writes: pointer already lowered when the word lands
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_wr <= 1'b0;
         mem_addr <= DATA_RST;
         mem_wdata <= DATA_RST;
      end else begin
         mem_wr <= ptr_dec;
         if (in_push) begin
            mem_addr <= push_addr;
            mem_wdata <= push_word;
         end else if (go_flags) begin
            mem_addr <= gpr[PTR_SLOT] - STACK_STEP;
            mem_wdata <= flags;
         end
      end
   end

   // Read data selection
   wire logic [DW-1:0] status_word = {14'h0000, done, busy};
   logic [DW-1:0] rd_mux;
   always_comb begin
      rd_mux = DATA_RST;
      case (reg_addr)
         OFS_CMD: rd_mux = cmd;
         OFS_FLAGS: rd_mux = flags;
         OFS_DEST: rd_mux = dest_opnd;
         OFS_IMM: rd_mux = imm_count;
         OFS_RESULT: rd_mux = cur_mem ? dest_opnd : gpr[cur_reg];
         OFS_STATUS: rd_mux = status_word;
         default: rd_mux = gpr_hit(reg_addr) ? gpr[reg_addr[2:0]] : DATA_RST;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= DATA_RST;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : DATA_RST;
      end
   end

   // Checks on the datapath
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   wire logic res_top = cur_word ? step_value[15] : step_value[7];
   wire logic res_next = cur_word ? step_value[14] : step_value[6];
   wire logic [DW-1:0] keep_mask = 16'hF7FE;

   push_first_a: assert property (
      go_all |-> ##2 (mem_wr && mem_wdata == $past(gpr[0], 2)))
      else $error("push-all first word is not the accumulator");
   push_last_a: assert property (
      go_all |-> ##9 (mem_wr && mem_wdata == $past(gpr[7], 9)))
      else $error("push-all last word is not the destination index");
   push_ptr_image_a: assert property (
      go_all |-> ##6 (mem_wr && mem_wdata == $past(stack_pointer, 6)))
      else $error("pushed pointer image is not the starting pointer");
   push_addr_a: assert property (mem_wr |-> mem_addr == stack_pointer)
      else $error("stack write not at the lowered pointer");
   push_all_ptr_a: assert property (
      go_all |-> ##9 stack_pointer == $past(stack_pointer, 9) - 16'h0010)
      else $error("push-all did not lower the pointer by sixteen");
   push_flags_a: assert property (
      go_flags |=> mem_wr && mem_wdata == $past(flags)
      && stack_pointer == $past(stack_pointer) - 16'h0002)
      else $error("push-flags word or pointer wrong");
   push_keep_flags_a: assert property (
      (go_all || in_push || go_flags) |=> flags == $past(flags))
      else $error("flags changed during a push");
   rot_left_step_a: assert property (
      in_rot && cur_left && cur_word |=> work == {$past(work[14:0]), $past(work_carry)}
      && work_carry == $past(work[15]))
      else $error("left rotate step wrong");
   rot_right_step_a: assert property (
      in_rot && !cur_left && cur_word |=> work == {$past(work_carry), $past(work[15:1])}
      && work_carry == $past(work[0]))
      else $error("right rotate step wrong");
   rot_count_src_a: assert property (
      go_rot && new_csrc && !zero_go |=> rot_cnt == $past(gpr[CNT_SLOT][7:0]))
      else $error("count not taken from the count low byte");
   rot_left_ovf_a: assert property (
      rot_fin && count_one && cur_left
      |=> flags[FLG_OVERFLOW] == ($past(res_top) ^ flags[FLG_CARRY]))
      else $error("left rotate overflow wrong");
   rot_right_ovf_a: assert property (
      rot_fin && count_one && !cur_left
      |=> flags[FLG_OVERFLOW] == ($past(res_top) ^ $past(res_next)))
      else $error("right rotate overflow wrong");
   rot_keep_flags_a: assert property (
      rot_fin |=> (flags & keep_mask) == ($past(flags) & keep_mask))
      else $error("rotate altered a flag other than carry or overflow");
   rot_zero_count_a: assert property (
      zero_go |=> !busy && flags == $past(flags) && stack_pointer == $past(stack_pointer))
      else $error("zero-count rotate changed state");
   // Operands of a running sequence cannot be disturbed from the port
   busy_refuse_a: assert property (
      busy && reg_wr |=> cmd == $past(cmd) && imm_count == $past(imm_count))
      else $error("register write accepted while a sequence runs");

   push_all_done_c: cover property (in_push && push_last);
   push_flags_c: cover property (go_flags);
   rot_one_c: cover property (rot_fin && count_one);
   rot_zero_c: cover property (zero_go);
   rot_mem_c: cover property (rot_fin && cur_mem);

endmodule : stack_push_and_carry_rotate
`default_nettype wire

// [src/stack_rot_pkg.sv]
// Constants and types for the stack save and carry rotate datapath.
// Shared by the datapath top and its two helper modules.
`default_nettype none
package stack_rot_pkg;
   localparam int DW = 16;
   localparam int AW = 5;
   localparam int CNT_W = 8;
   localparam int GPR_NUM = 8;
   // Register offsets (word index on the register port)
   localparam logic [AW-1:0] OFS_CMD = 5'h00;
   localparam logic [AW-1:0] OFS_FLAGS = 5'h01;
   localparam logic [AW-1:0] OFS_DEST = 5'h02;
   localparam logic [AW-1:0] OFS_IMM = 5'h03;
   localparam logic [AW-1:0] OFS_RESULT = 5'h04;
   localparam logic [AW-1:0] OFS_STATUS = 5'h05;
   // General registers sit at 0x08..0x0F, slot in the low three bits
   localparam logic [1:0] GPR_PAGE = 2'h1;
   // Command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_WORD_BIT = 2;
   localparam int CMD_CSRC_BIT = 3;
   localparam int CMD_MEM_BIT = 4;
   localparam int CMD_REG_LSB = 5;
   // Status word bits
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   // Flags word bits
   localparam int FLG_CARRY = 0;
   localparam int FLG_OVERFLOW = 11;
   // Reset values
   localparam logic [DW-1:0] FLAGS_RST = 16'h0000;
   localparam logic [DW-1:0] GPR_RST = 16'h0000;
   localparam logic [DW-1:0] DATA_RST = 16'h0000;
   // Stack sequencing
   localparam logic [DW-1:0] STACK_STEP = 16'h0002;
   localparam logic [2:0] CNT_SLOT = 3'h1;
   localparam logic [2:0] PTR_SLOT = 3'h4;
   localparam logic [2:0] LAST_SLOT = 3'h7;
   // Operations
   typedef enum logic [1:0] {
      OP_PUSH_ALL = 2'h0,
      OP_PUSH_FLAGS = 2'h1,
      OP_ROT_LEFT = 2'h2,
      OP_ROT_RIGHT = 2'h3
   } op_e;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PUSH = 3'b010,
      ST_ROT = 3'b100
   } state_e;
endpackage : stack_rot_pkg
`default_nettype wire

// [testbench/stack_mem_model.sv]
// Write-only model of the system memory that holds the stack.
// Assumes one word write per cycle and never stalls the datapath.
`default_nettype none
module stack_mem_model
   import stack_rot_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Word write port from the datapath
   input wire logic mem_wr,
   input wire logic [DW-1:0] mem_addr,
   input wire logic [DW-1:0] mem_wdata
);
   timeunit 1ns;
   timeprecision 100ps;
   // Byte store, low byte at the word address
   logic [7:0] store [logic [DW-1:0]];
   // Write log that the bench inspects in order
   logic [DW-1:0] addr_q [$];
   logic [DW-1:0] data_q [$];
   // Each word lands at the pointer and the pointer plus one
   always @(posedge core_clk) begin
      if (mem_wr === 1'b1) begin
         store[mem_addr] = mem_wdata[7:0];
         store[mem_addr + 16'h0001] = mem_wdata[15:8];
         addr_q.push_back(mem_addr);
         data_q.push_back(mem_wdata);
      end
   end
endmodule : stack_mem_model
`default_nettype wire

// [testbench/tb_stack_push_and_carry_rotate.sv]
// Self-checking bench for the stack save and carry rotate datapath.
// Assumes the package register map and the write-only stack memory model.
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_stack_push_and_carry_rotate import stack_rot_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [AW-1:0] reg_addr = '0;
   logic [DW-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DW-1:0] reg_rdata, mem_addr, mem_wdata, stack_pointer, flags;
   logic mem_wr, busy;
   int failures = 0;
   int n_compared = 0;
   logic [DW-1:0] gv [8] = '{16'hA1C3, 16'h0007, 16'h5D2E, 16'hB0B1, 16'h0200, 16'h7F80,
      16'h0102, 16'hFFFE};

   // Clock at 200 MHz
   always #2.5 core_clk = ~core_clk;

   stack_push_and_carry_rotate u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .busy(busy),
      .stack_pointer(stack_pointer), .flags(flags));
   stack_mem_model u_mem (.core_clk(core_clk), .mem_wr(mem_wr), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata));

   // One-cycle write strobe
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // One-cycle read strobe, data taken in the following cycle
   task automatic chk_rd(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] e);
      logic [DW-1:0] d;
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
      `CHK(nm, e, d)
   endtask : chk_rd

   // Bounded wait for the operation to finish, then let the last write land
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (busy !== 1'b0 && n < 600);
      if (n >= 600) begin
         failures++;
         $display("[ERR] busy expected 0 seen 1");
      end
      repeat (2) @(posedge core_clk);
   endtask : wait_idle

   // Reference rotate: returns overflow, carry and the operand
   function automatic logic [17:0] rot_ref(input logic [15:0] v, input logic c,
      input logic w, input logic l, input int n, input logic ov);
      logic [15:0] x;
      logic t;
      int top;
      top = w ? 15 : 7;
      x = w ? v : {8'h00, v[7:0]};
      for (int i = 0; i < n; i++) begin
         t = c;
         c = l ? x[top] : x[0];
         x = l ? (x << 1) : (x >> 1);
         if (l) x[0] = t;
         else x[top] = t;
      end
      if (n == 1) ov = l ? (x[top] ^ c) : (x[top] ^ x[top-1]);
      x = w ? x : {v[15:8], x[7:0]};
      return {ov, c, x};
   endfunction : rot_ref

   // Loads flags, counts and operand, runs one rotate and checks the outcome
   task automatic run_rot(input logic l, input logic w, input logic cs, input logic m,
      input logic [2:0] slot, input logic [7:0] n, input logic [15:0] v, input logic c);
      logic [17:0] e;
      logic [15:0] f0;
      f0 = 16'h8ED4 | {15'h0000, c};
      wr(OFS_FLAGS, f0);
      wr(OFS_IMM, {8'h5A, cs ? n + 8'h01 : n});
      wr({GPR_PAGE, CNT_SLOT}, {8'h03, cs ? n : n + 8'h02});
      wr(m ? OFS_DEST : {GPR_PAGE, slot}, v);
      wr(OFS_CMD, {8'h00, slot, m, cs, w, l ? 2'h2 : 2'h3});
      wait_idle();
      e = rot_ref(v, c, w, l, int'(n), 1'b1);
      chk_rd("result", OFS_RESULT, e[15:0]);
      chk_rd("target", m ? OFS_DEST : {GPR_PAGE, slot}, e[15:0]);
      chk_rd("status", OFS_STATUS, 16'h0002);
      `CHK("flags", {f0[15:12], e[17], f0[10:1], e[16]}, flags)
   endtask : run_rot

   // Counts and verdict; the single end of the run
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #100000;
      failures++;
      $display("[ERR] watchdog expected finish seen hang");
      summarize();
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      `CHK("reset pointer", 16'h0000, stack_pointer)
      chk_rd("unmapped", 5'h1F, 16'h0000);
      // Push-all with a known register set
      wr(OFS_FLAGS, 16'hC5AB);
      for (int i = 0; i < GPR_NUM; i++) wr({GPR_PAGE, 3'(i)}, gv[i]);
      u_mem.addr_q.delete();
      u_mem.data_q.delete();
      wr(OFS_CMD, 16'h0000);
      chk_rd("status busy", OFS_STATUS, 16'h0001);
      // A flags write while the sequence runs must be refused
      wr(OFS_FLAGS, 16'h0000);
      wait_idle();
      `CHK("push count", 8, u_mem.addr_q.size())
      for (int i = 0; i < 8; i++) begin
         `CHK("push addr", 16'h0200 - 16'(2 * (i + 1)), u_mem.addr_q[i])
         `CHK("push data", gv[i], u_mem.data_q[i])
      end
      `CHK("stack bytes", gv[0], {u_mem.store[16'h01FF], u_mem.store[16'h01FE]})
      `CHK("pointer", 16'h01F0, stack_pointer)
      chk_rd("status done", OFS_STATUS, 16'h0002);
      `CHK("flags", 16'hC5AB, flags)
      // Push-flags right after
      u_mem.addr_q.delete();
      u_mem.data_q.delete();
      wr(OFS_CMD, 16'h0001);
      repeat (3) @(posedge core_clk);
      `CHK("flag addr", 16'h01EE, u_mem.addr_q[0])
      `CHK("flag data", 16'hC5AB, u_mem.data_q[0])
      `CHK("pointer", 16'h01EE, stack_pointer)
      `CHK("flags", 16'hC5AB, flags)
      // Rotates over every direction, width, count source and target kind
      run_rot(1, 1, 0, 0, 3'h0, 8'h01, 16'h8001, 1'b0);
      run_rot(1, 1, 0, 0, 3'h7, 8'h01, 16'hC000, 1'b0);
      run_rot(1, 0, 1, 1, 3'h0, 8'h01, 16'h1240, 1'b1);
      run_rot(0, 1, 0, 1, 3'h0, 8'h01, 16'h4001, 1'b1);
      run_rot(0, 0, 1, 0, 3'h3, 8'h01, 16'hABC2, 1'b0);
      run_rot(0, 1, 0, 0, 3'h5, 8'h01, 16'h4000, 1'b1);
      run_rot(1, 1, 1, 0, 3'h6, 8'h05, 16'h0F0F, 1'b1);
      run_rot(0, 0, 0, 1, 3'h0, 8'h09, 16'h33CC, 1'b0);
      run_rot(0, 1, 0, 0, 3'h2, 8'h11, 16'h8421, 1'b1);
      run_rot(1, 1, 0, 0, 3'h5, 8'h00, 16'hBEEF, 1'b1);
      run_rot(0, 0, 1, 1, 3'h0, 8'h00, 16'h5A96, 1'b0);
      summarize();
   end
endmodule : tb_stack_push_and_carry_rotate
`undef CHK
`default_nettype wire
